// ==== dv/msrp_host_model.sv ====
// Host microcontroller model for the reset/wake pin and command select
`timescale 1ns/1ns
module msrp_host_model (
  input  wire logic clk,
  input  wire logic dev_oe,
  output logic      pin_level,
  output logic      cmd_n
);
  logic host_low;

  // ==========================================================
  // Open drain wire: either party pulls low, weak pull-up otherwise
  assign pin_level = !(host_low || dev_oe);

  // Host starts released and in transparent mode; hold_low and set_cmd(1) return it to these defaults
  initial begin
    host_low = 1'b0;
    cmd_n = 1'b1;
  end

  // Host only pulls low or lets go; never drives the pin high
  task automatic hold_low(input int n);
    @(posedge clk);
    host_low <= 1'b1;
    repeat (n) @(posedge clk);
    host_low <= 1'b0;
  endtask

  // Command mode select, changed right after an edge
  task automatic set_cmd(input logic v);
    @(posedge clk);
    cmd_n <= v;
  endtask
endmodule

// ==== dv/msrp_top_sva.sv ====
// Assertion checker for the status and reset pin block
`timescale 1ns/1ns
module msrp_top_sva #(
  parameter int POR_DELAY_CYC = 29999
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic supply_ok,
  input wire logic core_reset,
  input wire logic core_run,
  input wire logic deep_sleep,
  input wire logic io_release,
  input wire logic reset_wake_pin_in,
  input wire logic reset_wake_pin_out,
  input wire logic reset_wake_pin_oe,
  input wire logic tx_active,
  input wire logic rx_score_above,
  input wire logic rx_start_seq,
  input wire logic rx_pkt_done,
  input wire logic rf_search_en,
  input wire logic packet_activity_flag,
  input wire logic reply_valid,
  input wire logic reply_ready,
  input wire logic uart_tx_valid,
  input wire logic reply_active_n
);
  int lo_cnt;
  int up_cnt;
  int next_lo_cnt;
  int next_up_cnt;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ==========================================================
  // Pin low time and supply-good time, saturating so they never wrap
  always_comb begin
    next_lo_cnt = reset_wake_pin_in ? 0 : (lo_cnt < 4000 ? lo_cnt + 1 : lo_cnt);
    next_up_cnt = !supply_ok ? 0 : (up_cnt < 40000 ? up_cnt + 1 : up_cnt);
  end

  // Counters registered on the block clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lo_cnt <= 0;
      up_cnt <= 0;
    end else begin
      lo_cnt <= next_lo_cnt;
      up_cnt <= next_up_cnt;
    end
  end

  // ==========================================================
  // Packet activity and search
  chk_flag_score: assert property (rf_search_en && rx_score_above && !rx_pkt_done
    |=> packet_activity_flag) else $error("flag not raised on score");
  chk_flag_done: assert property (rx_pkt_done |=> !packet_activity_flag)
    else $error("flag kept after packet end");
  chk_flag_latch: assert property (rf_search_en && rx_start_seq && !rx_pkt_done
    ##1 (rf_search_en && !rx_pkt_done && !rx_score_above) |=> packet_activity_flag)
    else $error("flag not latched by start sequence");
  chk_search_gate: assert property (tx_active || core_run
    |-> rf_search_en == (core_run && !tx_active)) else $error("search enable wrong");

  // ==========================================================
  // Reply indicator
  chk_reply_tx: assert property (!reply_active_n && !io_release |-> uart_tx_valid)
    else $error("reply indicator low with nothing sent");
  chk_reply_take: assert property (reply_valid && reply_ready
    |-> ##[1:2] !reply_active_n) else $error("reply indicator did not fall");

  // ==========================================================
  // Reset/wake pin
  chk_pin_drive: assert property (reset_wake_pin_oe |-> !reset_wake_pin_out)
    else $error("pin driven high");
  chk_pin_suspend: assert property (!reset_wake_pin_in [*4]
    |-> io_release && !core_run) else $error("not suspended while pin low");
  chk_hwrst_min: assert property ($rose(core_reset) && supply_ok && $past(supply_ok)
    |-> lo_cnt >= 1500) else $error("reset from short pulse");
  chk_hwrst_due: assert property (lo_cnt == 1600 |-> core_reset || deep_sleep)
    else $error("no reset after long low");
  chk_brownout: assert property (!supply_ok
    |-> ##[1:2] (reset_wake_pin_oe && core_reset)) else $error("brown-out not signalled");
  chk_por_len: assert property ($fell(reset_wake_pin_oe)
    |-> up_cnt >= POR_DELAY_CYC && up_cnt <= POR_DELAY_CYC + 3)
    else $error("power-on delay wrong");

  // Main scenarios reached
  cov_latch: cover property (rx_start_seq ##1 packet_activity_flag);
  cov_hwrst: cover property ($rose(core_reset) && supply_ok);
  cov_wake: cover property ($fell(deep_sleep));
  cov_reply: cover property (!reply_active_n && uart_tx_valid);
endmodule

bind msrp_top msrp_top_sva #(.POR_DELAY_CYC(POR_DELAY_CYC)) u_sva (
  .clk, .rst_n, .supply_ok, .core_reset, .core_run, .deep_sleep, .io_release,
  .reset_wake_pin_in, .reset_wake_pin_out, .reset_wake_pin_oe, .tx_active,
  .rx_score_above, .rx_start_seq, .rx_pkt_done, .rf_search_en, .packet_activity_flag,
  .reply_valid, .reply_ready, .uart_tx_valid, .reply_active_n
);

// ==== dv/tb_top.sv ====
// Self-checking bench for the status and reset pin block
`timescale 1ns/1ns
module tb_top;
  import msrp_pkg::*;
  localparam int POR = 20;
  typedef struct packed {logic score, start, done, tx, flag, srch;} msrp_row_t;

  // ==========================================================
  // Design signals, all inputs given a value at time zero
  logic clk = 1'b0, rst_n = 1'b0, supply_ok = 1'b0, sleep_req = 1'b0, ram_ok = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic core_reset, core_run, soft_reset, deep_sleep, io_release, pin_w, pin_oe;
  logic tx_active = 1'b0, rx_score_above = 1'b0, rx_start_seq = 1'b0, rx_pkt_done = 1'b0;
  logic rf_search_en, packet_activity_flag, rf_rx_ready, reply_ready, command_select_n;
  logic rf_rx_valid = 1'b0, reply_valid = 1'b0, uart_tx_ready = 1'b1;
  msrp_byte_t rf_rx_data = 8'h00, reply_data = 8'h00, uart_tx_data;
  logic uart_tx_valid, reply_active_n, soft_seen = 1'b0;
  logic [8:0] seen [$];
  int num_errors = 0, compares = 0, cyc = 0;
  msrp_row_t rows [9] = '{6'b100011, 6'b000001, 6'b010011, 6'b000011, 6'b001001,
                          6'b100100, 6'b100011, 6'b001001, 6'b000001};

  always #5 clk = ~clk;

  msrp_top #(.POR_DELAY_CYC(POR)) i_dut (
    .clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .supply_ok, .sleep_req, .ram_ok, .core_reset, .core_run,
    .soft_reset, .deep_sleep, .io_release, .reset_wake_pin_in(pin_w),
    .reset_wake_pin_out(), .reset_wake_pin_oe(pin_oe), .tx_active, .rx_score_above,
    .rx_start_seq, .rx_pkt_done, .rf_search_en, .packet_activity_flag, .rf_rx_valid,
    .rf_rx_data, .rf_rx_ready, .reply_valid, .reply_data, .reply_ready, .command_select_n,
    .uart_tx_valid, .uart_tx_data, .uart_tx_ready, .reply_active_n
  );

  msrp_host_model i_host (.clk, .dev_oe(pin_oe), .pin_level(pin_w), .cmd_n(command_select_n));

  // ==========================================================
  // Serial output log, soft reset catch and run ceiling
  always @(posedge clk) begin
    if (uart_tx_valid && uart_tx_ready)
      seen.push_back({reply_active_n, uart_tx_data});
    if (soft_reset)
      soft_seen <= 1'b1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      give_verdict();
    end
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Avalon request held until the rising edge after waitrequest is seen low at a falling edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    logic done;
    done = 1'b0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    while (!done) begin
      @(negedge clk);
      done = !avs_waitrequest;
      q = avs_readdata;
      @(posedge clk);
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // One byte offered as RF data or as a command reply, held until ready
  task automatic send(input logic rep, input msrp_byte_t b);
    logic done;
    done = 1'b0;
    @(posedge clk);
    reply_valid <= rep;
    reply_data <= b;
    rf_rx_valid <= !rep;
    rf_rx_data <= b;
    while (!done) begin
      @(negedge clk);
      done = rep ? reply_ready : rf_rx_ready;
      @(posedge clk);
    end
    reply_valid <= 1'b0;
    rf_rx_valid <= 1'b0;
  endtask

  // Supply comes good; pin must stay low for the power-on delay, then run
  task automatic por_wait(input string t);
    int n;
    logic [31:0] q;
    n = 0;
    @(posedge clk);
    supply_ok <= 1'b1;
    do begin
      @(negedge clk);
      n++;
    end while (pin_oe !== 1'b0 && n < 1000);
    check("por_cycles_in_window", 1, n >= POR + 1 && n <= POR + 3);
    bus(1'b0, 4'h4, 0, q);
    check("state_run", 1, q[2:0]);
    $display("test %s done", t);
  endtask

  // Low pulse on the pin with a look at the block near its end
  task automatic pulse(input int n, input logic exp_rst);
    fork
      i_host.hold_low(n);
      begin
        repeat (n - 10) @(negedge clk);
        check("io_release", 1, io_release);
        check("core_run", 0, core_run);
        check("core_reset", exp_rst, core_reset);
      end
    join
    repeat (10) @(negedge clk);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    logic [31:0] q;
    repeat (6) @(posedge clk);
    check("pin_oe_in_reset", 1, pin_oe);
    rst_n <= 1'b1;
    por_wait("power_up");
    // Hold control readback and an unmapped place
    bus(1'b1, 4'h0, 32'h0000_0001, q);
    bus(1'b0, 4'h0, 0, q);
    check("ctrl", 32'h0000_0001, q);
    bus(1'b0, 4'h8, 0, q);
    check("unmapped", 0, q);
    // Ordinary packet activity cases
    foreach (rows[i]) begin
      @(posedge clk);
      {rx_score_above, rx_start_seq, rx_pkt_done, tx_active} <= rows[i][5:2];
      @(posedge clk);
      @(negedge clk);
      check("flag", rows[i].flag, packet_activity_flag);
      check("search", rows[i].srch, rf_search_en);
    end
    $display("test packet_rows done");
    // RF bytes held in command mode while a reply still goes out
    i_host.set_cmd(1'b0);
    send(1'b0, 8'h5a);
    send(1'b0, 8'ha5);
    send(1'b1, 8'h3c);
    repeat (10) @(negedge clk);
    bus(1'b0, 4'h4, 0, q);
    check("held_count", 2, q[8:6]);
    check("out_count_held", 1, seen.size());
    uart_tx_ready <= 1'b0;
    i_host.set_cmd(1'b1);
    repeat (5) @(posedge clk);
    uart_tx_ready <= 1'b1;
    repeat (20) @(negedge clk);
    check("out_count", 3, seen.size());
    check("out_reply", 9'h03c, seen[0]);
    check("out_rf0", 9'h15a, seen[1]);
    check("out_rf1", 9'h1a5, seen[2]);
    $display("test hold_resume done");
    // Short and long lows while running
    pulse(100, 1'b0);
    bus(1'b0, 4'h4, 0, q);
    check("state_after_short", 1, q[2:0]);
    pulse(1600, 1'b1);
    bus(1'b0, 4'h4, 0, q);
    check("state_after_reset", 1, q[2:0]);
    $display("test pin_reset done");
    // Deep sleep, refused short wake, real wake with corrupted memory
    @(posedge clk);
    sleep_req <= 1'b1;
    @(posedge clk);
    sleep_req <= 1'b0;
    ram_ok <= 1'b0;
    @(negedge clk);
    check("asleep", 1, deep_sleep);
    pulse(100, 1'b0);
    check("still_asleep", 1, deep_sleep);
    pulse(1600, 1'b0);
    check("awake", 0, deep_sleep);
    check("soft_reset_seen", 1, soft_seen);
    @(posedge clk);
    ram_ok <= 1'b1;
    $display("test sleep_wake done");
    // Brown-out
    @(posedge clk);
    supply_ok <= 1'b0;
    // Long enough that the own pull-down would qualify as a pin reset if not masked
    repeat (1600) @(negedge clk);
    check("brownout_pin", 1, pin_oe);
    check("brownout_reset", 1, core_reset);
    por_wait("brownout");
    give_verdict();
  end
endmodule

// ==== logic/msrp_consts.svh ====
// Constants of the module status and reset pin block
`ifndef MSRP_CONSTS_SVH
`define MSRP_CONSTS_SVH

// ==========================================================
// Timing
`define MSRP_CLK_PERIOD_NS 10
`define MSRP_MIN_LOW_US    15
`define MSRP_MIN_LOW_CYC   ((`MSRP_MIN_LOW_US * 1000 + `MSRP_CLK_PERIOD_NS - 1) / `MSRP_CLK_PERIOD_NS)
`define MSRP_LOW_CNT_W     11
`define MSRP_POR_DELAY_US  300
`define MSRP_POR_DELAY_CYC ((`MSRP_POR_DELAY_US * 1000 / `MSRP_CLK_PERIOD_NS) - 1)
`define MSRP_POR_CNT_W     15

// ==========================================================
// Register map and fields
`define MSRP_REG_CTRL      4'h0
`define MSRP_REG_STATUS    4'h4
`define MSRP_CTRL_RST      8'h00
`define MSRP_HOLD_ON       8'h01
`define MSRP_ST_PIN_LOW    3
`define MSRP_ST_PKT        4
`define MSRP_ST_REPLY_N    5
`define MSRP_ST_CNT_LSB    6
`define MSRP_ST_HOLD       9

// ==========================================================
// Hold buffer
`define MSRP_HOLD_DEPTH    3'h4
`define MSRP_HOLD_IDX_W    2

`endif

// ==== logic/msrp_pin_filter.sv ====
// Synchroniser and low-time qualifier for the reset/wake pin
`timescale 1ns/1ns
`include "msrp_consts.svh"

module msrp_pin_filter (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic pin_in,
  output logic      pin_low,
  output logic      low_qual,
  output logic      rise_pulse
);

  localparam logic [`MSRP_LOW_CNT_W-1:0] MIN_LOW = `MSRP_LOW_CNT_W'(`MSRP_MIN_LOW_CYC);

  logic                       sync1;
  logic                       sync2;
  logic [`MSRP_LOW_CNT_W-1:0] low_cnt;
  logic                       qual;
  logic                       next_qual;
  logic [`MSRP_LOW_CNT_W-1:0] next_low_cnt;
  logic                       next_rise;

  // ==========================================================
  // Low-time counting; only sync2 is looked at
  always_comb begin
    next_low_cnt = low_cnt;
    next_qual    = qual;
    next_rise    = 1'b0;
    if (sync2) begin
      next_low_cnt = '0;
      next_qual    = 1'b0;
      next_rise    = qual;
    end else if (low_cnt != MIN_LOW) begin
      next_low_cnt = low_cnt + 1'b1;
    end else begin
      next_qual = 1'b1;
    end
  end

  // Pull-up makes the idle level high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1      <= 1'b1;
      sync2      <= 1'b1;
      low_cnt    <= '0;
      qual       <= 1'b0;
      rise_pulse <= 1'b0;
    end else begin
      sync1      <= pin_in;
      sync2      <= sync1;
      low_cnt    <= next_low_cnt;
      qual       <= next_qual;
      rise_pulse <= next_rise;
    end
  end

  assign pin_low  = ~sync2;
  assign low_qual = qual;

endmodule

// ==== logic/msrp_pkg.sv ====
// Types shared by the status and reset pin block
package msrp_pkg;

  // ==========================================================
  // Controller life cycle
  typedef enum logic [2:0] {
    MSRP_POR,
    MSRP_RUN,
    MSRP_HWRST,
    MSRP_SLEEP,
    MSRP_WAKE
  } msrp_state_t;

  typedef logic [7:0] msrp_byte_t;

endpackage

// ==== logic/msrp_top.sv ====
// Status pins, serial output steering and reset/wake pin control
`timescale 1ns/1ns
`include "msrp_consts.svh"

module msrp_top #(
  parameter int POR_DELAY_CYC = `MSRP_POR_DELAY_CYC
) (
  input  wire logic               clk,
  input  wire logic               rst_n,

  // Avalon-MM slave
  input  wire logic [3:0]         avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [31:0]        avs_writedata,
  output logic [31:0]             avs_readdata,
  output logic                    avs_waitrequest,

  // Supply monitor and controller
  input  wire logic               supply_ok,
  input  wire logic               sleep_req,
  input  wire logic               ram_ok,
  output logic                    core_reset,
  output logic                    core_run,
  output logic                    soft_reset,
  output logic                    deep_sleep,
  output logic                    io_release,

  // Reset/wake pin, open drain
  input  wire logic               reset_wake_pin_in,
  output logic                    reset_wake_pin_out,
  output logic                    reset_wake_pin_oe,

  // RF receive scoring
  input  wire logic               tx_active,
  input  wire logic               rx_score_above,
  input  wire logic               rx_start_seq,
  input  wire logic               rx_pkt_done,
  output logic                    rf_search_en,
  output logic                    packet_activity_flag,

  // Received RF bytes
  input  wire logic               rf_rx_valid,
  input  wire msrp_pkg::msrp_byte_t rf_rx_data,
  output logic                    rf_rx_ready,

  // Command reply bytes
  input  wire logic               reply_valid,
  input  wire msrp_pkg::msrp_byte_t reply_data,
  output logic                    reply_ready,

  // Serial transmit byte stream and mode pin
  input  wire logic               command_select_n,
  output logic                    uart_tx_valid,
  output msrp_pkg::msrp_byte_t    uart_tx_data,
  input  wire logic               uart_tx_ready,
  output logic                    reply_active_n
);

  import msrp_pkg::*;

  // ==========================================================
  // Declarations
  msrp_state_t                state;
  msrp_state_t                next_state;
  logic [`MSRP_POR_CNT_W-1:0] por_cnt;
  logic [`MSRP_POR_CNT_W-1:0] next_por_cnt;
  logic                       next_soft_reset;
  logic                       next_pin_oe;

  logic pin_low;
  logic low_qual;
  logic rise_pulse;
  logic run;
  logic flush;

  logic ack;
  logic next_ack;
  logic [31:0] next_readdata;
  msrp_byte_t  command_data_hold_ctrl;
  msrp_byte_t  next_hold_ctrl;

  logic search;
  logic pkt_latch;
  logic next_pkt_latch;
  logic next_pkt_flag;

  msrp_byte_t                 hold_mem [`MSRP_HOLD_DEPTH];
  logic [`MSRP_HOLD_IDX_W-1:0] wr_idx;
  logic [`MSRP_HOLD_IDX_W-1:0] rd_idx;
  logic [2:0]                 hold_cnt;
  logic [`MSRP_HOLD_IDX_W-1:0] next_wr_idx;
  logic [`MSRP_HOLD_IDX_W-1:0] next_rd_idx;
  logic [2:0]                 next_hold_cnt;
  logic                       holding;
  logic                       push;
  logic                       pop;
  logic                       slot_free;
  logic                       take_reply;

  logic       tx_is_reply;
  logic       next_tx_valid;
  logic       next_tx_is_reply;
  msrp_byte_t next_tx_data;
  logic       next_reply_n;

  // ==========================================================
  // Pin qualification; own pull-down is masked so a long power-on low is no reset
  msrp_pin_filter u_filter (
    .clk        (clk),
    .rst_n      (rst_n),
    .pin_in     (reset_wake_pin_in || reset_wake_pin_oe),
    .pin_low    (pin_low),
    .low_qual   (low_qual),
    .rise_pulse (rise_pulse)
  );

  // ==========================================================
  // Life cycle; the state survives deep sleep, which is what
  // tells a wake pulse apart from a reset pulse
  always_comb begin
    next_state      = state;
    next_por_cnt    = '0;
    next_soft_reset = 1'b0;
    unique case (state)
      MSRP_POR: begin
        if (supply_ok) begin
          if (por_cnt == `MSRP_POR_CNT_W'(POR_DELAY_CYC)) begin
            next_state = MSRP_RUN;
          end else begin
            next_por_cnt = por_cnt + 1'b1;
          end
        end
      end
      MSRP_RUN: begin
        if (low_qual) begin
          next_state = MSRP_HWRST;
        end else if (sleep_req && !pin_low) begin
          if (ram_ok) begin
            next_state = MSRP_SLEEP;
          end else begin
            next_soft_reset = 1'b1;
          end
        end
      end
      MSRP_HWRST: begin
        if (!pin_low) begin
          next_state = MSRP_RUN;
        end
      end
      MSRP_SLEEP: begin
        if (rise_pulse) begin
          next_state = MSRP_WAKE;
        end
      end
      MSRP_WAKE: begin
        next_state      = MSRP_RUN;
        next_soft_reset = !ram_ok;
      end
    endcase
    // Brown-out overrides every state change and restarts the delay
    if (!supply_ok) begin
      next_state   = MSRP_POR;
      next_por_cnt = '0;
    end
    next_pin_oe = (next_state == MSRP_POR);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state             <= MSRP_POR;
      por_cnt           <= '0;
      soft_reset        <= 1'b0;
      reset_wake_pin_oe <= 1'b1;
    end else begin
      state             <= next_state;
      por_cnt           <= next_por_cnt;
      soft_reset        <= next_soft_reset;
      reset_wake_pin_oe <= next_pin_oe;
    end
  end

  // Open drain: only ever pulls low, the pull-up gives the high
  assign reset_wake_pin_out = 1'b0;

  // Any low level suspends work at once, before qualification
  assign run        = (state == MSRP_RUN) && !pin_low;
  assign flush      = (state == MSRP_POR) || (state == MSRP_HWRST);
  assign core_reset = flush;
  assign core_run   = run;
  assign deep_sleep = (state == MSRP_SLEEP);
  assign io_release = pin_low || flush;

  // ==========================================================
  // Avalon-MM slave: one wait cycle on every access
  always_comb begin
    next_ack       = (avs_read || avs_write) && !ack;
    next_hold_ctrl = command_data_hold_ctrl;
    next_readdata  = 32'h0000_0000;
    if (avs_write && ack && avs_address == `MSRP_REG_CTRL) begin
      next_hold_ctrl = avs_writedata[7:0];
    end
    if (avs_read && !ack) begin
      unique case (avs_address)
        `MSRP_REG_CTRL: begin
          next_readdata[7:0] = command_data_hold_ctrl;
        end
        `MSRP_REG_STATUS: begin
          next_readdata[2:0]              = state;
          next_readdata[`MSRP_ST_PIN_LOW] = pin_low;
          next_readdata[`MSRP_ST_PKT]     = packet_activity_flag;
          next_readdata[`MSRP_ST_REPLY_N] = reply_active_n;
          next_readdata[`MSRP_ST_CNT_LSB +: 3] = hold_cnt;
          next_readdata[`MSRP_ST_HOLD]    = holding;
        end
        default: begin
          next_readdata = 32'h0000_0000;      // Unmapped reads zero
        end
      endcase
    end else begin
      next_readdata = avs_readdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack                    <= 1'b0;
      avs_readdata           <= 32'h0000_0000;
      command_data_hold_ctrl <= `MSRP_CTRL_RST;
    end else begin
      ack                    <= next_ack;
      avs_readdata           <= next_readdata;
      command_data_hold_ctrl <= next_hold_ctrl;
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && !ack;

  // ==========================================================
  // Packet activity; a start sequence latches the flag so a
  // weak preamble score can no longer drop it mid-packet
  assign search       = run && !tx_active;
  assign rf_search_en = search;

  always_comb begin
    next_pkt_latch = pkt_latch;
    if (!search || rx_pkt_done) begin
      next_pkt_latch = 1'b0;
    end else if (rx_start_seq) begin
      next_pkt_latch = 1'b1;
    end
    next_pkt_flag = search && !rx_pkt_done &&
                    (next_pkt_latch || rx_score_above);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pkt_latch            <= 1'b0;
      packet_activity_flag <= 1'b0;
    end else begin
      pkt_latch            <= next_pkt_latch;
      packet_activity_flag <= next_pkt_flag;
    end
  end

  // ==========================================================
  // RF byte hold buffer; every RF byte passes through it so
  // held bytes leave in arrival order once the hold ends
  assign holding = (command_data_hold_ctrl == `MSRP_HOLD_ON)
                   && !command_select_n;
  assign rf_rx_ready = run && (hold_cnt != `MSRP_HOLD_DEPTH);
  assign push        = rf_rx_valid && rf_rx_ready;
  assign slot_free   = !uart_tx_valid || uart_tx_ready;
  assign take_reply  = run && slot_free && reply_valid;
  assign reply_ready = run && slot_free;
  assign pop = run && slot_free && !reply_valid &&
               !holding && (hold_cnt != 3'h0);

  always_comb begin
    next_wr_idx   = wr_idx;
    next_rd_idx   = rd_idx;
    next_hold_cnt = hold_cnt;
    if (flush) begin
      next_wr_idx   = '0;
      next_rd_idx   = '0;
      next_hold_cnt = 3'h0;
    end else begin
      if (push) begin
        next_wr_idx = wr_idx + 1'b1;
      end
      if (pop) begin
        next_rd_idx = rd_idx + 1'b1;
      end
      next_hold_cnt = hold_cnt + {2'b00, push} - {2'b00, pop};
    end
  end

  // Storage itself has no reset; contents count only below hold_cnt
  always_ff @(posedge clk) begin
    if (push) begin
      hold_mem[wr_idx] <= rf_rx_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_idx   <= '0;
      rd_idx   <= '0;
      hold_cnt <= 3'h0;
    end else begin
      wr_idx   <= next_wr_idx;
      rd_idx   <= next_rd_idx;
      hold_cnt <= next_hold_cnt;
    end
  end

  // ==========================================================
  // Serial transmit slot; replies go first so they are never
  // stuck behind held RF data
  always_comb begin
    next_tx_valid    = uart_tx_valid;
    next_tx_data     = uart_tx_data;
    next_tx_is_reply = tx_is_reply;
    if (flush || pin_low) begin
      next_tx_valid    = 1'b0;
      next_tx_is_reply = 1'b0;
    end else if (slot_free) begin
      next_tx_valid    = take_reply || pop;
      next_tx_is_reply = take_reply;
      if (take_reply) begin
        next_tx_data = reply_data;
      end else if (pop) begin
        next_tx_data = hold_mem[rd_idx];
      end
    end
    next_reply_n = !(next_tx_valid && next_tx_is_reply);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      uart_tx_valid  <= 1'b0;
      uart_tx_data   <= 8'h00;
      tx_is_reply    <= 1'b0;
      reply_active_n <= 1'b1;
    end else begin
      uart_tx_valid  <= next_tx_valid;
      uart_tx_data   <= next_tx_data;
      tx_is_reply    <= next_tx_is_reply;
      reply_active_n <= next_reply_n;
    end
  end

endmodule
